// ===== common/flut_pkg.sv
// Contract
// - threshold register holds 7-bit threshold in bits 6:0, resets to 0x7f
// - threshold bit 7 is unused and always reads zero
// - each duty register holds 6-bit duty in bits 5:0, resets to 0x3f
// - duty bits 7:6 are unused and always read zero
// - temperature above threshold at 0x58 selects duty at 0x59
// - temperature above threshold at 0x5a selects duty at 0x5b
// - temperature above threshold at 0x5c selects duty at 0x5d
// - temperature above eighth threshold selects duty at 0x5f
`default_nettype none
package flut_pkg;

    // widths
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int IDX_W   = 8;
    localparam int THR_W   = 7;
    localparam int DUTY_W  = 6;
    localparam int TEMP_W  = 8;
    localparam int N_ENTRY = 4;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_THR5  = 8'h58;
    localparam logic [IDX_W-1:0] IDX_DUTY5 = 8'h59;
    localparam logic [IDX_W-1:0] IDX_THR6  = 8'h5a;
    localparam logic [IDX_W-1:0] IDX_DUTY6 = 8'h5b;
    localparam logic [IDX_W-1:0] IDX_THR7  = 8'h5c;
    localparam logic [IDX_W-1:0] IDX_DUTY7 = 8'h5d;
    localparam logic [IDX_W-1:0] IDX_THR8  = 8'h5e;
    localparam logic [IDX_W-1:0] IDX_DUTY8 = 8'h5f;
    localparam logic [IDX_W-1:0] IDX_CTRL  = 8'h60;
    localparam logic [IDX_W-1:0] IDX_STAT  = 8'h61;

    // number of the first entry held here
    localparam logic [2:0] FIRST_ENTRY = 3'h5;

    // reset values
    localparam logic [THR_W-1:0]  THR_RST  = 7'h7f;
    localparam logic [DUTY_W-1:0] DUTY_RST = 6'h3f;
    localparam logic              EN_RST   = 1'h1;

    // control field positions
    localparam int CTRL_EN_POS = 0;

    // status field positions
    localparam int STAT_ENTRY_LSB = 0;
    localparam int STAT_HIT_POS   = 3;
    localparam int STAT_DUTY_LSB  = 8;

    // apb request from the master
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } flut_apb_req_type;

    // apb answer to the master
    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } flut_apb_rsp_type;

    // table selection result
    typedef struct packed {
        logic              hit;
        logic [2:0]        entry;
        logic [DUTY_W-1:0] duty;
    } flut_sel_type;

    // whole state of the table block
    typedef struct packed {
        logic [N_ENTRY-1:0][THR_W-1:0]  thr;
        logic [N_ENTRY-1:0][DUTY_W-1:0] duty;
        logic                           table_en;
        logic [DATA_W-1:0]              rd_data;
        logic                           rd_err;
        flut_sel_type                   sel;
    } flut_state_type;

endpackage
`default_nettype wire

// ===== design/flut_entry.sv
`timescale 1ns/1ns
`default_nettype none
module flut_entry #(
    parameter int THR_W  = 7,
    parameter int TEMP_W = 8
) (
    // temperature and threshold
    input  wire logic [TEMP_W-1:0] i_temp,
    input  wire logic [THR_W-1:0]  i_thr,
    // compare result
    output logic                   o_exceed
);

    // two's complement temperature; negatives never exceed a threshold
    assign o_exceed = !i_temp[TEMP_W-1] &&
                      (i_temp[TEMP_W-2:0] > (TEMP_W-1)'(i_thr));

endmodule
`default_nettype wire

// ===== design/flut_top.sv
`timescale 1ns/1ns
`default_nettype none
module flut_top #(
    parameter int N_ENTRY = flut_pkg::N_ENTRY
) (
    // clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst,
    // apb slave port
    input  wire flut_pkg::flut_apb_req_type i_apb,
    output flut_pkg::flut_apb_rsp_type      o_apb,
    // remote diode temperature, whole degrees, two's complement
    input  wire logic [flut_pkg::TEMP_W-1:0] i_remote_temp,
    // selected fan duty
    output logic [flut_pkg::DUTY_W-1:0]     o_pwm_duty,
    output logic                            o_table_hit,
    output logic [2:0]                      o_hit_entry
);

    // state register and its next value
    flut_pkg::flut_state_type state_r;
    flut_pkg::flut_state_type state_nxt;

    // per-entry compare results
    logic [N_ENTRY-1:0] exceed;

    // decoded bus access
    logic [flut_pkg::IDX_W-1:0] acc_idx;
    logic                       acc_aligned;
    logic                       setup_phase;
    logic                       access_phase;
    logic                       wr_take;

    // combinational choice from the compare results
    flut_pkg::flut_sel_type sel_now;

    // reset image of the whole state
    flut_pkg::flut_state_type state_rst;

    // reset image built from package constants
    always_comb begin
        state_rst          = '0;
        state_rst.table_en = flut_pkg::EN_RST;
        for (int e = 0; e < N_ENTRY; e++) begin
            state_rst.thr[e]  = flut_pkg::THR_RST;
            state_rst.duty[e] = flut_pkg::DUTY_RST;
        end
    end

    // one comparator per table entry
    genvar g;
    generate
        for (g = 0; g < N_ENTRY; g++) begin : g_entry
            flut_entry #(
                .THR_W  (flut_pkg::THR_W),
                .TEMP_W (flut_pkg::TEMP_W)
            ) u_entry (
                .i_temp   (i_remote_temp),
                .i_thr    (state_r.thr[g]),
                .o_exceed (exceed[g])
            );
        end
    endgenerate

    // pick the exceeded entry; later entries override earlier ones
    always_comb begin
        sel_now = '0;
        for (int e = 0; e < N_ENTRY; e++) begin
            if (exceed[e]) begin
                sel_now.hit   = 1'h1;
                sel_now.entry = flut_pkg::FIRST_ENTRY + 3'(e);
                sel_now.duty  = state_r.duty[e];
            end
        end
    end

    // apb phase and address decode
    assign acc_idx      = i_apb.paddr[flut_pkg::IDX_W+1:2];
    assign acc_aligned  = (i_apb.paddr[1:0] == 2'h0) &&
                          (i_apb.paddr[flut_pkg::ADDR_W-1:
                                       flut_pkg::IDX_W+2] == '0);
    assign setup_phase  = i_apb.psel && !i_apb.penable;
    assign access_phase = i_apb.psel && i_apb.penable;
    assign wr_take      = access_phase && i_apb.pwrite && !state_r.rd_err;

    // threshold index of entry e
    function automatic logic [flut_pkg::IDX_W-1:0] thr_idx(input int e);
        thr_idx = flut_pkg::IDX_THR5 + flut_pkg::IDX_W'(2 * e);
    endfunction

    // duty index of entry e
    function automatic logic [flut_pkg::IDX_W-1:0] duty_idx(input int e);
        duty_idx = flut_pkg::IDX_DUTY5 + flut_pkg::IDX_W'(2 * e);
    endfunction

    // next state: bus reads at setup, writes at access, output choice
    always_comb begin
        logic                       hit_reg;
        logic [flut_pkg::DATA_W-1:0] rdata;
        hit_reg   = 1'h0;
        rdata     = '0;
        state_nxt = state_r;

        // read data and error are captured in the setup cycle
        if (setup_phase) begin
            if (acc_aligned) begin
                for (int e = 0; e < N_ENTRY; e++) begin
                    if (acc_idx == thr_idx(e)) begin
                        hit_reg = 1'h1;
                        // bit 7 and above read zero
                        rdata = 32'(state_r.thr[e]);
                    end
                    if (acc_idx == duty_idx(e)) begin
                        hit_reg = 1'h1;
                        // bits 7:6 and above read zero
                        rdata = 32'(state_r.duty[e]);
                    end
                end
                if (acc_idx == flut_pkg::IDX_CTRL) begin
                    hit_reg = 1'h1;
                    rdata[flut_pkg::CTRL_EN_POS] = state_r.table_en;
                end
                if (acc_idx == flut_pkg::IDX_STAT) begin
                    hit_reg = 1'h1;
                    rdata[flut_pkg::STAT_ENTRY_LSB +: 3] = state_r.sel.entry;
                    rdata[flut_pkg::STAT_HIT_POS]        = state_r.sel.hit;
                    rdata[flut_pkg::STAT_DUTY_LSB +: flut_pkg::DUTY_W] =
                        state_r.sel.duty;
                end
            end
            state_nxt.rd_data = i_apb.pwrite ? '0 : rdata;
            state_nxt.rd_err  = !hit_reg;
        end

        // writes land on the access edge; unmapped writes are dropped
        if (wr_take) begin
            for (int e = 0; e < N_ENTRY; e++) begin
                if (acc_idx == thr_idx(e)) begin
                    // only the low seven bits are stored
                    state_nxt.thr[e] =
                        i_apb.pwdata[flut_pkg::THR_W-1:0];
                end
                if (acc_idx == duty_idx(e)) begin
                    // only the low six bits are stored
                    state_nxt.duty[e] =
                        i_apb.pwdata[flut_pkg::DUTY_W-1:0];
                end
            end
            if (acc_idx == flut_pkg::IDX_CTRL) begin
                state_nxt.table_en = i_apb.pwdata[flut_pkg::CTRL_EN_POS];
            end
        end

        // registered fan duty; table off or no hit leaves it at zero
        if (state_r.table_en) begin
            state_nxt.sel = sel_now;
        end else begin
            state_nxt.sel = '0;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= state_rst;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bus answer: zero wait states, data captured in setup
    assign o_apb.prdata  = state_r.rd_data;
    assign o_apb.pready  = 1'h1;
    assign o_apb.pslverr = access_phase && state_r.rd_err;

    // selection outputs from flip-flops
    assign o_pwm_duty  = state_r.sel.duty;
    assign o_table_hit = state_r.sel.hit;
    assign o_hit_entry = state_r.sel.entry;

endmodule
`default_nettype wire

// ===== testbench/flut_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module flut_top_assertions #(
    parameter int N_ENTRY = 4
) (
    // clock and reset
    input wire logic                        i_clk_sys,
    input wire logic                        i_rst,
    // apb port
    input wire flut_pkg::flut_apb_req_type  i_apb,
    input wire flut_pkg::flut_apb_rsp_type  o_apb,
    // table link
    input wire logic [flut_pkg::TEMP_W-1:0] i_remote_temp,
    input wire logic [flut_pkg::DUTY_W-1:0] o_pwm_duty,
    input wire logic                        o_table_hit,
    input wire logic [2:0]                  o_hit_entry
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // setup then access, and a cycle with steady temperature and no write
    sequence s_xfer;
        i_apb.psel && !i_apb.penable ##1 i_apb.psel && i_apb.penable;
    endsequence
    sequence s_quiet;
        $stable(i_remote_temp) && !(i_apb.psel && i_apb.pwrite);
    endsequence
    // bus answer checks
    AST_READY: assert property (o_apb.pready)
        else $error("pready low");
    AST_ERR_PHASE: assert property (o_apb.pslverr |-> i_apb.penable)
        else $error("pslverr outside access");
    AST_ERR_ALIGN: assert property (s_xfer ##0 i_apb.paddr[1:0] != 2'h0
        |-> o_apb.pslverr) else $error("misaligned access accepted");
    AST_ERR_RANGE: assert property (s_xfer ##0 i_apb.paddr[11:10] != 2'h0
        |-> o_apb.pslverr) else $error("high address accepted");
    AST_ERR_DATA: assert property (o_apb.pslverr |-> o_apb.prdata == '0)
        else $error("refused read returned data");
    // table output checks
    AST_RST_CLEAR: assert property (disable iff (1'b0)
        i_rst |=> !o_table_hit && o_pwm_duty == '0)
        else $error("outputs not cleared by reset");
    AST_NEG_NO_HIT: assert property (
        i_remote_temp[flut_pkg::TEMP_W-1] |=> !o_table_hit)
        else $error("negative temperature hit");
    AST_NO_HIT_ZERO: assert property (
        !o_table_hit |-> o_pwm_duty == '0 && o_hit_entry == 3'h0)
        else $error("duty without hit");
    AST_QUIET: assert property (s_quiet ##1 s_quiet |=>
        $stable(o_pwm_duty) && $stable(o_table_hit))
        else $error("output moved without cause");
endmodule
bind flut_top flut_top_assertions #(.N_ENTRY(N_ENTRY)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
    .i_remote_temp(i_remote_temp), .o_pwm_duty(o_pwm_duty),
    .o_table_hit(o_table_hit), .o_hit_entry(o_hit_entry));
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                       i_clk_sys     = 1'b0;
    logic                       i_rst         = 1'b1;
    flut_pkg::flut_apb_req_type i_apb         = '0;
    flut_pkg::flut_apb_rsp_type o_apb;
    logic [7:0]                 i_remote_temp = 8'h00;
    logic [5:0]                 o_pwm_duty;
    logic                       o_table_hit;
    logic [2:0]                 o_hit_entry;
    int                         mismatches    = 0;
    int                         check_count   = 0;
    logic [31:0]                rd_data;
    logic                       rd_err;
    logic [11:0]                bad [4] =
        '{12'h000, 12'h162, 12'h560, 12'h188};

    flut_top DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_apb(i_apb),
        .o_apb(o_apb), .i_remote_temp(i_remote_temp),
        .o_pwm_duty(o_pwm_duty), .o_table_hit(o_table_hit),
        .o_hit_entry(o_hit_entry));

    // 50 mhz clock
    always #10 i_clk_sys = ~i_clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer after an idle cycle
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge i_clk_sys);
        i_apb.paddr   <= a;
        i_apb.pwrite  <= wr;
        i_apb.pwdata  <= d;
        i_apb.psel    <= 1'b1;
        @(posedge i_clk_sys);
        i_apb.penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_apb.pready !== 1'b1);
        rd_data = o_apb.prdata;
        rd_err  = o_apb.pslverr;
        i_apb.psel    <= 1'b0;
        i_apb.penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic err);
        xfer(1'b0, a, 32'h0);
        chk(rd_data, exp);
        chk({31'h0, rd_err}, {31'h0, err});
    endtask
    // new temperature, outputs one edge later
    task automatic tmp(input logic [7:0] t, input logic [5:0] duty,
                       input logic [3:0] ent);
        @(posedge i_clk_sys);
        i_remote_temp <= t;
        @(posedge i_clk_sys);
        #1;
        chk({26'h0, o_pwm_duty}, {26'h0, duty});
        chk({31'h0, o_table_hit}, {31'h0, ent != 4'h0});
        // entry 8 does not fit three bits and reads back as zero
        chk({29'h0, o_hit_entry}, {29'h0, ent[2:0]});
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(12'h160 + 12'(8 * i), 32'h7f, 1'b0);
            rd(12'h164 + 12'(8 * i), 32'h3f, 1'b0);
        end
        tmp(8'h7f, 6'h00, 4'h0);
        $display("test reset values done");
        xfer(1'b1, 12'h168, 32'hffff_ffa5);
        xfer(1'b1, 12'h16c, 32'hffff_ffe9);
        rd(12'h168, 32'h25, 1'b0);
        rd(12'h16c, 32'h29, 1'b0);
        foreach (bad[k]) rd(bad[k], 32'h0, 1'b1);
        xfer(1'b1, 12'h162, 32'h0);
        rd(12'h160, 32'h7f, 1'b0);
        $display("test register access done");
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 12'h160 + 12'(8 * i), 32'(16 * (i + 1)));
            xfer(1'b1, 12'h164 + 12'(8 * i), 32'(17 + i));
        end
        tmp(8'h05, 6'h00, 4'h0);
        tmp(8'h11, 6'h11, 4'h5);
        tmp(8'h20, 6'h11, 4'h5);
        tmp(8'h21, 6'h12, 4'h6);
        tmp(8'h31, 6'h13, 4'h7);
        tmp(8'h7f, 6'h14, 4'h8);
        tmp(8'h80, 6'h00, 4'h0);
        xfer(1'b1, 12'h178, 32'h08);
        tmp(8'h35, 6'h14, 4'h8);
        $display("test table select done");
        // status shows duty, hit and wrapped entry; control gates output
        rd(12'h184, 32'h0000_1408, 1'b0);
        rd(12'h180, 32'h0000_0001, 1'b0);
        xfer(1'b1, 12'h180, 32'h0);
        tmp(8'h35, 6'h00, 4'h0);
        rd(12'h184, 32'h0, 1'b0);
        xfer(1'b1, 12'h180, 32'h1);
        tmp(8'h35, 6'h14, 4'h8);
        $display("test control and status done");
        complete_run;
    end
    // hang guard
    initial begin
        repeat (4000) @(posedge i_clk_sys);
        mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
